//--- hol_pkg.sv
// Constants and types for the channel and module status indicator block
package hol_pkg;
   localparam longint HOL_CLK_HZ = 125_000_000;

   // Register byte addresses
   localparam logic [3:0] HOL_ADDR_CTRL = 4'h0;
   localparam logic [3:0] HOL_ADDR_STATUS = 4'h4;
   localparam logic [3:0] HOL_ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] HOL_ADDR_IRQ_MASK = 4'hc;

   // Control register fields
   localparam int HOL_CTRL_FORCE_BIT = 0;
   localparam int HOL_CTRL_CONFIG_BIT = 1;
   localparam int HOL_CTRL_TMO_LSB = 2;
   localparam int HOL_TMO_W = 3;
   localparam logic [HOL_TMO_W-1:0] HOL_TMO_RESET = 3'h0;

   // Status register fields
   localparam int HOL_ST_PWR_BIT = 0;
   localparam int HOL_ST_COMM_BIT = 1;
   localparam int HOL_ST_EXT_BIT = 2;
   localparam int HOL_ST_INT_BIT = 3;
   localparam int HOL_ST_LED_LSB = 8;

   // Interrupt event bits
   localparam int HOL_IRQ_W = 3;
   localparam int HOL_IRQ_EXT_BIT = 0;
   localparam int HOL_IRQ_COMM_BIT = 1;
   localparam int HOL_IRQ_FAIL_BIT = 2;

   localparam int HOL_NCHAN = 8;
   localparam logic [HOL_NCHAN-1:0] HOL_FAIL_XOR = 8'hff;

   localparam logic [1:0] HOL_RESP_OKAY = 2'h0;
   localparam logic [1:0] HOL_RESP_SLVERR = 2'h2;

   // Communication timeout periods in milliseconds, indexed by the select code
   localparam longint HOL_TMO_MS [0:7] = '{16000, 4000, 2000, 1000, 500, 250, 125, 62};
   // End-of-conversion watchdog window in microseconds
   localparam longint HOL_EOC_WIN_US = 1000;

   typedef logic [31:0] hol_cnt_t;
   typedef hol_cnt_t hol_tmo_tab_t [0:7];

   function automatic hol_tmo_tab_t hol_tmo_cycles();
      hol_tmo_tab_t t;
      for (int i = 0; i < 8; i++) begin
         t[i] = hol_cnt_t'(HOL_TMO_MS[i] * HOL_CLK_HZ / 1000);
      end
      return t;
   endfunction

   localparam hol_tmo_tab_t HOL_TMO_CYC = hol_tmo_cycles();
   localparam hol_cnt_t HOL_EOC_WIN_CYC = hol_cnt_t'(HOL_EOC_WIN_US * HOL_CLK_HZ / 1000000);
endpackage

//--- hol_wdog_if.sv
// Interface between the status block and its reloadable watchdog counters
`timescale 1ns/1ps
interface hol_wdog_if;
   import hol_pkg::*;
   hol_cnt_t load_val;
   logic kick;
   logic expired;
   modport wd (input load_val, input kick, output expired);
   modport user (output load_val, output kick, input expired);
endinterface

//--- hol_watchdog.sv
// Reloadable down-counting watchdog
`timescale 1ns/1ps
module hol_watchdog
   import hol_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   hol_wdog_if.wd w
);
   hol_cnt_t cnt;
   hol_cnt_t next_cnt;
   logic loaded;
   logic next_loaded;

   // First load after reset happens unconditionally so a silent source still times out
   always_comb begin
      next_cnt = cnt;
      next_loaded = 1'b1;
      if (w.kick || !loaded) begin
         next_cnt = w.load_val;
      end else if (cnt != '0) begin
         next_cnt = cnt - hol_cnt_t'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= '0;
         loaded <= 1'b0;
      end else begin
         cnt <= next_cnt;
         loaded <= next_loaded;
      end
   end

   assign w.expired = loaded && (cnt == '0);
endmodule

//--- hol_status_leds.sv
// Module status and channel activity indicator logic with AXI4-Lite registers
`timescale 1ns/1ps
module hol_status_leds
   import hol_pkg::*;
#(
   parameter hol_tmo_tab_t COMM_TMO_CYC = HOL_TMO_CYC,
   parameter hol_cnt_t EOC_WIN_CYC = HOL_EOC_WIN_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pwr5v_good,
   input wire logic eoc,
   input wire logic diag_prom_fail,
   input wire logic diag_ee_fail,
   input wire logic diag_ram_fail,
   input wire logic msg_sent,
   input wire logic [2:0] msg_chan,
   input wire logic resp_ok,
   input wire logic resp_fail,
   output logic led_power,
   output logic led_comm,
   output logic led_ext_err,
   output logic led_int_err,
   output logic [HOL_NCHAN-1:0] led_chan,
   output logic irq
);
   // Pin synchronisers
   logic pwr_s1, pwr_s2, eoc_s1, eoc_s2, eoc_s3;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_s1 <= 1'b0;
         pwr_s2 <= 1'b0;
         eoc_s1 <= 1'b0;
         eoc_s2 <= 1'b0;
         eoc_s3 <= 1'b0;
      end else begin
         pwr_s1 <= pwr5v_good;
         pwr_s2 <= pwr_s1;
         eoc_s1 <= eoc;
         eoc_s2 <= eoc_s1;
         eoc_s3 <= eoc_s2;
      end
   end

   // Register bus state
   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [3:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic w_lane0, next_w_lane0;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic force_err, next_force_err, configured, next_configured;
   logic [HOL_TMO_W-1:0] tmo_sel, next_tmo_sel;
   logic [HOL_IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
   logic [HOL_IRQ_W-1:0] irq_evt;
   logic [31:0] status_word;
   logic do_write, do_read, bus_activity;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;

   assign do_write = aw_held && w_held && !bvalid;
   assign do_read = s_axi_arvalid && !rvalid;
   // Any completed access counts as controller traffic
   assign bus_activity = do_write || do_read;

   always_comb begin
      status_word = '0;
      status_word[HOL_ST_PWR_BIT] = led_power;
      status_word[HOL_ST_COMM_BIT] = led_comm;
      status_word[HOL_ST_EXT_BIT] = led_ext_err;
      status_word[HOL_ST_INT_BIT] = led_int_err;
      status_word[HOL_ST_LED_LSB +: HOL_NCHAN] = led_chan;
   end

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_lane0 = w_lane0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_force_err = force_err;
      next_configured = configured;
      next_tmo_sel = tmo_sel;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_lane0 = s_axi_wstrb[0];
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = HOL_RESP_OKAY;
         case (aw_addr)
            HOL_ADDR_CTRL: begin
               if (w_lane0) begin
                  next_force_err = w_data[HOL_CTRL_FORCE_BIT];
                  next_configured = w_data[HOL_CTRL_CONFIG_BIT];
                  next_tmo_sel = w_data[HOL_CTRL_TMO_LSB +: HOL_TMO_W];
               end
            end
            HOL_ADDR_STATUS: ;
            HOL_ADDR_IRQ_STAT: begin
               if (w_lane0) begin
                  next_irq_stat = irq_stat & ~w_data[HOL_IRQ_W-1:0];
               end
            end
            HOL_ADDR_IRQ_MASK: begin
               if (w_lane0) begin
                  next_irq_mask = w_data[HOL_IRQ_W-1:0];
               end
            end
            default: next_bresp = HOL_RESP_SLVERR;
         endcase
      end
      // A new event wins over a same-cycle clear
      next_irq_stat = next_irq_stat | irq_evt;
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (do_read) begin
         next_rvalid = 1'b1;
         next_rresp = HOL_RESP_OKAY;
         next_rdata = '0;
         case ({s_axi_araddr[3:2], 2'h0})
            HOL_ADDR_CTRL: begin
               next_rdata[HOL_CTRL_FORCE_BIT] = force_err;
               next_rdata[HOL_CTRL_CONFIG_BIT] = configured;
               next_rdata[HOL_CTRL_TMO_LSB +: HOL_TMO_W] = tmo_sel;
            end
            HOL_ADDR_STATUS: next_rdata = status_word;
            HOL_ADDR_IRQ_STAT: next_rdata[HOL_IRQ_W-1:0] = irq_stat;
            HOL_ADDR_IRQ_MASK: next_rdata[HOL_IRQ_W-1:0] = irq_mask;
            default: next_rresp = HOL_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= HOL_RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= HOL_RESP_OKAY;
         rdata <= '0;
         force_err <= 1'b0;
         configured <= 1'b0;
         tmo_sel <= HOL_TMO_RESET;
         irq_stat <= '0;
         irq_mask <= '0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_lane0 <= next_w_lane0;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         force_err <= next_force_err;
         configured <= next_configured;
         tmo_sel <= next_tmo_sel;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // Watchdogs for controller traffic and conversion activity
   hol_wdog_if comm_wd ();
   hol_wdog_if eoc_wd ();

   // A write that changes the selection already arms the new period
   assign comm_wd.load_val = COMM_TMO_CYC[next_tmo_sel];
   assign comm_wd.kick = bus_activity;
   assign eoc_wd.load_val = EOC_WIN_CYC;
   assign eoc_wd.kick = eoc_s2 ^ eoc_s3;

   hol_watchdog u_comm_wd (
      .aclk(aclk),
      .aresetn(aresetn),
      .w(comm_wd.wd)
   );

   hol_watchdog u_eoc_wd (
      .aclk(aclk),
      .aresetn(aresetn),
      .w(eoc_wd.wd)
   );

   // Module indicators and channel pattern
   logic comm_seen, next_comm_seen, comm_lost, next_comm_lost;
   logic ext_err, int_err, ext_d, comm_lost_d;
   logic [HOL_NCHAN-1:0] chan, next_chan, onehot;
   logic [2:0] cur_chan, next_cur_chan;

   assign ext_err = eoc_wd.expired;
   // Field power loss deliberately stays out of this term
   assign int_err = force_err || comm_lost || diag_prom_fail || diag_ee_fail
                    || diag_ram_fail;
   assign onehot = HOL_NCHAN'(1) << msg_chan;

   assign irq_evt[HOL_IRQ_EXT_BIT] = ext_err && !ext_d;
   assign irq_evt[HOL_IRQ_COMM_BIT] = comm_lost && !comm_lost_d;
   assign irq_evt[HOL_IRQ_FAIL_BIT] = resp_fail && configured;

   always_comb begin
      next_comm_seen = comm_seen;
      next_comm_lost = comm_lost;
      if (bus_activity) begin
         next_comm_seen = 1'b1;
         next_comm_lost = 1'b0;
      end else if (comm_wd.expired && comm_seen) begin
         next_comm_seen = 1'b0;
         next_comm_lost = 1'b1;
      end
      next_cur_chan = (msg_sent && configured) ? msg_chan : cur_chan;
   end

   // A new message replaces any failure pattern with its own one-hot
   for (genvar i = 0; i < HOL_NCHAN; i++) begin : g_chan
      always_comb begin
         next_chan[i] = chan[i];
         if (!configured) begin
            next_chan[i] = 1'b0;
         end else if (msg_sent) begin
            next_chan[i] = onehot[i];
         end else if (resp_fail) begin
            next_chan[i] = (cur_chan == 3'(i)) ^ HOL_FAIL_XOR[i];
         end else if (resp_ok && cur_chan == 3'(i)) begin
            next_chan[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         comm_seen <= 1'b0;
         comm_lost <= 1'b0;
         chan <= '0;
         cur_chan <= '0;
         ext_d <= 1'b0;
         comm_lost_d <= 1'b0;
         led_power <= 1'b0;
         led_comm <= 1'b0;
         led_ext_err <= 1'b0;
         led_int_err <= 1'b0;
      end else begin
         comm_seen <= next_comm_seen;
         comm_lost <= next_comm_lost;
         chan <= next_chan;
         cur_chan <= next_cur_chan;
         ext_d <= ext_err;
         comm_lost_d <= comm_lost;
         led_power <= pwr_s2;
         led_comm <= next_comm_seen;
         led_ext_err <= ext_err;
         led_int_err <= int_err;
      end
   end

   assign led_chan = chan;
endmodule

//--- hol_status_leds_monitor.sv
// Port-level assertions for the status indicator block
`timescale 1ns/1ps
module hol_status_leds_monitor
   import hol_pkg::*;
#(
   parameter hol_tmo_tab_t COMM_TMO_CYC = HOL_TMO_CYC,
   parameter hol_cnt_t EOC_WIN_CYC = HOL_EOC_WIN_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic pwr5v_good,
   input wire logic eoc,
   input wire logic diag_prom_fail,
   input wire logic diag_ee_fail,
   input wire logic diag_ram_fail,
   input wire logic msg_sent,
   input wire logic [2:0] msg_chan,
   input wire logic resp_ok,
   input wire logic resp_fail,
   input wire logic led_power,
   input wire logic led_comm,
   input wire logic led_ext_err,
   input wire logic led_int_err,
   input wire logic [HOL_NCHAN-1:0] led_chan
);
   logic [3:0] up_cnt;
   logic [3:0] next_up_cnt;
   hol_cnt_t idle_cnt;
   hol_cnt_t next_idle_cnt;
   logic eoc_q;
   always_comb begin
      next_up_cnt = (up_cnt == 4'hf) ? up_cnt : up_cnt + 4'h1;
      next_idle_cnt = (eoc != eoc_q) ? '0 : idle_cnt + 32'h1;
   end
   // Idle count restarts with reset, as the watchdog reloads after release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_cnt <= 4'h0;
         idle_cnt <= '0;
      end else begin
         up_cnt <= next_up_cnt;
         idle_cnt <= next_idle_cnt;
      end
      eoc_q <= eoc;
   end
   default clocking mon_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_msg_lit;
      msg_sent ##1 (led_chan != 8'h00);
   endsequence
   sequence s_wr_done;
      s_axi_bvalid && s_axi_bready;
   endsequence
   a_power_follows: assert property ((up_cnt >= 4'h4) |-> led_power == $past(pwr5v_good, 3))
      else $error("power indicator does not follow supply good");
   a_comm_lit: assert property (s_wr_done |-> ##[1:3] led_comm)
      else $error("communication indicator not lit after traffic");
   a_ext_set: assert property ((idle_cnt == EOC_WIN_CYC + 8) |-> led_ext_err)
      else $error("external error missing after strobe stopped");
   a_ext_clear: assert property ((idle_cnt == 32'h9) |-> !led_ext_err)
      else $error("external error lit while strobe toggles");
   a_diag_error: assert property ((diag_prom_fail || diag_ee_fail || diag_ram_fail) |=> led_int_err)
      else $error("internal error missing on diagnostic fault");
   a_msg_onehot: assert property (s_msg_lit |-> led_chan == (8'h01 << $past(msg_chan)))
      else $error("channel indicator not one-hot for sent channel");
   a_ok_clears: assert property ($onehot(led_chan) && resp_ok && !msg_sent && !resp_fail |=> led_chan == 8'h00)
      else $error("channel indicator not cleared by response");
   a_fail_invert: assert property ($onehot(led_chan) && resp_fail && !msg_sent |=> led_chan == ~$past(led_chan))
      else $error("failure pattern is not the inverted channel");
   a_fail_hold: assert property (($countones(led_chan) == 7) && !msg_sent |=> $stable(led_chan))
      else $error("failure pattern changed without a new message");
   a_bresp_okay: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == HOL_RESP_OKAY)
      else $error("write response is not okay");
endmodule

//--- hol_field_model.sv
// Behavioural field side: message and response source, converter strobe
`timescale 1ns/1ps
module hol_field_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic field_pwr,
   input wire logic go,
   input wire logic [2:0] go_chan,
   input wire logic go_fail,
   input wire logic [7:0] go_dly,
   output logic msg_sent,
   output logic [2:0] msg_chan,
   output logic resp_ok,
   output logic resp_fail,
   output logic eoc
);
   logic [7:0] dly;
   logic [3:0] half;
   logic pend;
   logic fail_q;
   initial begin
      msg_sent = 1'b0;
      msg_chan = 3'h0;
      resp_ok = 1'b0;
      resp_fail = 1'b0;
      eoc = 1'b0;
   end
   always @(posedge aclk) begin
      msg_sent <= 1'b0;
      resp_ok <= 1'b0;
      resp_fail <= 1'b0;
      // Channel lines wander between messages so no stale value is trusted
      msg_chan <= msg_chan + 3'h1;
      half <= (half == 4'h9) ? 4'h0 : half + 4'h1;
      // Strobe stops while field power is gone
      if (half == 4'h9 && field_pwr) eoc <= ~eoc;
      if (!aresetn) begin
         pend <= 1'b0;
         half <= 4'h0;
         eoc <= 1'b0;
      end else if (go) begin
         msg_sent <= 1'b1;
         msg_chan <= go_chan;
         dly <= go_dly;
         fail_q <= go_fail;
         pend <= 1'b1;
      end else if (pend) begin
         if (dly == 8'h0) begin
            pend <= 1'b0;
            resp_ok <= ~fail_q;
            resp_fail <= fail_q;
         end else begin
            dly <= dly - 8'h1;
         end
      end
   end
endmodule

//--- tb_hol_status_leds.sv
// Self-checking bench for the status indicator block
`timescale 1ns/1ps
module tb_hol_status_leds;
   import hol_pkg::*;
   localparam hol_tmo_tab_t TMO = '{800, 400, 200, 100, 50, 25, 12, 6};
   localparam hol_cnt_t WIN = 50;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic pwr = 0, fpwr = 1, go = 0, fail = 0;
   logic awready, wready, bvalid, arready, rvalid, irq, msg, rok, rfail, eoc, lp, lc, le, li;
   logic [3:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp;
   logic [2:0] diag = 0, gch = 0, mch;
   logic [7:0] gdly = 0, lch;
   int num_errors = 0, num_checks = 0, seed = 32'h4ded6698, cyc = 0;
   hol_status_leds #(.COMM_TMO_CYC(TMO), .EOC_WIN_CYC(WIN)) hol_status_leds_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pwr5v_good(pwr), .eoc(eoc), .diag_prom_fail(diag[0]), .diag_ee_fail(diag[1]),
      .diag_ram_fail(diag[2]), .msg_sent(msg), .msg_chan(mch), .resp_ok(rok), .resp_fail(rfail),
      .led_power(lp), .led_comm(lc), .led_ext_err(le), .led_int_err(li), .led_chan(lch),
      .irq(irq));
   hol_field_model hol_field_model_inst (.aclk(aclk), .aresetn(aresetn), .field_pwr(fpwr),
      .go(go), .go_chan(gch), .go_fail(fail), .go_dly(gdly), .msg_sent(msg), .msg_chan(mch),
      .resp_ok(rok), .resp_fail(rfail), .eoc(eoc));
   initial begin
      forever #4 aclk = ~aclk;
   end
   function automatic logic [7:0] after(input logic [2:0] ch, input logic fl);
      after = fl ? (8'h01 << ch) ^ HOL_FAIL_XOR : 8'h00;
   endfunction
   task automatic stop_test();
      if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   // Handshakes are taken at the rising edge, before the design's registers move
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic bt;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bt = 1'b0;
      while (!bt) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         bt = bvalid && bready;
         if (bt) bready <= 1'b0;
      end
      chk(32'(bresp), 32'(HOL_RESP_OKAY));
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      logic rt;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rt = 1'b0;
      d = '0;
      while (!rt) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         rt = rvalid && rready;
         if (rt) begin
            d = rdata;
            rready <= 1'b0;
         end
      end
      chk(32'(rresp), 32'(HOL_RESP_OKAY));
   endtask
   task automatic send(input logic [2:0] ch, input logic fl, input logic [7:0] d);
      logic [31:0] v;
      @(posedge aclk);
      go <= 1'b1;
      gch <= ch;
      fail <= fl;
      gdly <= d;
      @(posedge aclk);
      go <= 1'b0;
      cy(2);
      chk(lch, 8'h01 << ch);
      cy(d);
      chk(lch, after(ch, fl));
      rd(HOL_ADDR_STATUS, v);
      cy(4);
      chk(v[15:8], after(ch, fl));
      chk(lch, after(ch, fl));
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      logic [31:0] v;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(HOL_ADDR_CTRL, v);
      chk(v, 32'h0);
      cy(TMO[0] - 12);
      chk(lc, 1'b1);
      cy(20);
      chk({lc, li}, 2'b01);
      for (int i = 0; i < 6; i++) begin
         @(posedge aclk);
         pwr <= 1'($random(seed));
         cy(4);
         chk(lp, pwr);
      end
      for (int k = 0; k < 8; k++) begin
         wr(HOL_ADDR_CTRL, 32'h2 | (32'(k) << HOL_CTRL_TMO_LSB));
         cy(TMO[k] - 4);
         chk(lc, 1'b1);
         cy(10);
         chk({lc, li}, 2'b01);
      end
      wr(HOL_ADDR_CTRL, 32'h3);
      cy(2);
      chk(li, 1'b1);
      wr(HOL_ADDR_CTRL, 32'h2);
      cy(2);
      chk(li, 1'b0);
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         diag <= 3'(1 << i);
         cy(2);
         chk(li, 1'b1);
         @(posedge aclk);
         diag <= 3'h0;
         cy(2);
         chk(li, 1'b0);
      end
      @(posedge aclk);
      fpwr <= 1'b0;
      cy(WIN + 20);
      chk({le, li}, 2'b10);
      @(posedge aclk);
      fpwr <= 1'b1;
      cy(30);
      chk(le, 1'b0);
      send(3'h7, 1'b1, 8'h1);
      send(3'h0, 1'b0, 8'h1);
      for (int i = 0; i < 24; i++) begin
         send(3'($random(seed)), 1'($random(seed)), 8'(2 + ($random(seed) & 15)));
      end
      rd(HOL_ADDR_IRQ_STAT, v);
      chk(v[2:0], 3'h7);
      chk(irq, 1'b0);
      wr(HOL_ADDR_IRQ_MASK, 32'h4);
      cy(1);
      chk(irq, 1'b1);
      wr(HOL_ADDR_IRQ_STAT, 32'h4);
      cy(1);
      chk(irq, 1'b0);
      rd(HOL_ADDR_IRQ_MASK, v);
      chk(v, 32'h4);
      stop_test();
   end
endmodule
bind hol_status_leds hol_status_leds_monitor #(.COMM_TMO_CYC(COMM_TMO_CYC),
   .EOC_WIN_CYC(EOC_WIN_CYC)) hol_status_leds_monitor_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .pwr5v_good(pwr5v_good), .eoc(eoc), .diag_prom_fail(diag_prom_fail),
   .diag_ee_fail(diag_ee_fail), .diag_ram_fail(diag_ram_fail), .msg_sent(msg_sent),
   .msg_chan(msg_chan), .resp_ok(resp_ok), .resp_fail(resp_fail), .led_power(led_power),
   .led_comm(led_comm), .led_ext_err(led_ext_err), .led_int_err(led_int_err),
   .led_chan(led_chan));
